/* dv/tb_timer_counter_start_control.sv */
// Testbench for the counter start control block
`timescale 1ns/1ps
module tb_timer_counter_start_control;
   import tcs_pkg::*;
   logic        clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
   logic        hw_standby = 1'b0, sw_standby = 1'b0, hreadyout, hresp;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, r;
   logic [15:0] cnt;
   logic        run_ch10, run_ch10_event, run_ch10_noise, run_ch5, run_ch4, run_ch3, run_ch1_b;
   logic        run_ch2_b, run_ch2_a, run_ch1_a, run_ch0, run_ch7_d, run_ch7_c, run_ch7_b;
   logic        run_ch7_a, run_ch6_d, run_ch6_c, run_ch6_b, run_ch6_a, run_ch11;
   int          err_count = 0, n_checks = 0;
   wire [7:0] runs_a = {run_ch10, run_ch5, run_ch4, run_ch3, run_ch1_b, run_ch2_a, run_ch1_a,
                        run_ch0};
   wire [7:0] runs_b = {run_ch7_d, run_ch7_c, run_ch7_b, run_ch7_a, run_ch6_d, run_ch6_c,
                        run_ch6_b, run_ch6_a};

   tcs_start_ctrl DUT (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hw_standby, .sw_standby,
      .ch11_count_tick(tick), .run_ch10, .run_ch10_event, .run_ch10_noise, .run_ch5,
      .run_ch4, .run_ch3, .run_ch1_b, .run_ch2_b, .run_ch2_a, .run_ch1_a, .run_ch0,
      .run_ch7_d, .run_ch7_c, .run_ch7_b, .run_ch7_a, .run_ch6_d, .run_ch6_c, .run_ch6_b,
      .run_ch6_a, .run_ch11, .ch11_free_counter(cnt));

   always #50 clock = ~clock;

   task test_done;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Waits for hready under a bounded count
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         err_count++;
         $display("[FAIL] hready timeout expected 1 seen %b", hreadyout);
         test_done;
      end
   endtask

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      r = hrdata;
   endtask

   task pulse(input int n);
      repeat (n) begin
         @(posedge clock);
         tick <= 1'b1;
         @(posedge clock);
         tick <= 1'b0;
      end
   endtask

   task t_reset_values;
      for (int i = 0; i < 3; i++) begin
         ahb(1'b0, 8'(4 * i), 32'h0000_0000);
         chk("reset register", r, 32'h0000_0000);
      end
      chk("reset run enables", {runs_a, runs_b, run_ch11}, 32'h0000_0000);
      chk("channel 10 free counters", {30'h0, run_ch10_event, run_ch10_noise}, 32'h0000_0003);
      chk("bus response", {31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask

   task t_patterns;
      logic [7:0] p;
      for (int i = 0; i < 9; i++) begin
         p = 8'(9'h001 << i);
         ahb(1'b1, OFFSET_GROUP_A, {24'h00_0000, p});
         ahb(1'b1, OFFSET_GROUP_B, {24'h00_0000, ~p});
         ahb(1'b0, OFFSET_GROUP_A, 32'h0000_0000);
         chk("group a readback", r, {24'h00_0000, p});
         ahb(1'b0, OFFSET_GROUP_B, 32'h0000_0000);
         chk("group b readback", r, {24'h00_0000, ~p});
         chk("group a runs", {24'h00_0000, runs_a}, {24'h00_0000, p});
         chk("channel 2 b run", {31'h0, run_ch2_b}, {31'h0, p[3]});
         chk("group b runs", {24'h00_0000, runs_b}, {24'h00_0000, ~p});
      end
   endtask

   task t_group_c;
      ahb(1'b1, OFFSET_GROUP_C, 32'hFFFF_FFFF);
      ahb(1'b0, OFFSET_GROUP_C, 32'h0000_0000);
      chk("group c readback", r, 32'h0000_0001);
      chk("channel 11 run", {31'h0, run_ch11}, 32'h0000_0001);
      ahb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped read", r, 32'h0000_0000);
   endtask

   task t_counter;
      ahb(1'b1, OFFSET_CH11, 32'h0000_0000);
      pulse(5);
      ahb(1'b0, OFFSET_CH11, 32'h0000_0000);
      chk("counter running", r, 32'h0000_0005);
      ahb(1'b1, OFFSET_GROUP_C, 32'h0000_0000);
      pulse(4);
      chk("counter halted", {16'h0000, cnt}, 32'h0000_0005);
      ahb(1'b1, OFFSET_GROUP_C, 32'h0000_0001);
      pulse(3);
      ahb(1'b0, OFFSET_CH11, 32'h0000_0000);
      chk("counter resumed", r, 32'h0000_0008);
   endtask

   task t_standby;
      for (int s = 0; s < 2; s++) begin
         ahb(1'b1, OFFSET_GROUP_A, 32'h0000_00FF);
         ahb(1'b1, OFFSET_GROUP_B, 32'h0000_00FF);
         @(posedge clock);
         hw_standby <= (s == 0);
         sw_standby <= (s == 1);
         repeat (4) @(posedge clock);
         hw_standby <= 1'b0;
         sw_standby <= 1'b0;
         repeat (4) @(posedge clock);
         for (int i = 0; i < 3; i++) begin
            ahb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk("standby register", r, 32'h0000_0000);
         end
         chk("standby runs", {runs_a, runs_b, run_ch11}, 32'h0000_0000);
      end
   endtask

   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      t_reset_values;
      t_patterns;
      t_group_c;
      t_counter;
      t_standby;
      test_done;
   end
endmodule // tb_timer_counter_start_control

/* dv/tcs_start_ctrl_props.sv */
// Assertion checker for the counter start control block
`timescale 1ns/1ps
module tcs_start_ctrl_props (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        hw_standby,
   input wire logic        sw_standby,
   input wire logic        run_ch10,
   input wire logic        run_ch10_event,
   input wire logic        run_ch10_noise,
   input wire logic        run_ch1_b,
   input wire logic        run_ch2_b,
   input wire logic        run_ch0,
   input wire logic        run_ch7_d,
   input wire logic        run_ch6_a,
   input wire logic        run_ch11
);
   import tcs_pkg::*;
   wire quiet = !hw_standby && !sw_standby;
   wire halted = !run_ch10 && !run_ch0 && !run_ch7_d && !run_ch11;
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence s_write(logic [7:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == a && quiet ##1 quiet;
   endsequence
   a_write_group_a: assert property (s_write(OFFSET_GROUP_A) |=>
      run_ch10 == $past(hwdata[7]) && run_ch0 == $past(hwdata[0]))
      else $error("group a write lost");
   a_write_group_b: assert property (s_write(OFFSET_GROUP_B) |=>
      run_ch7_d == $past(hwdata[7]) && run_ch6_a == $past(hwdata[0]))
      else $error("group b write lost");
   a_write_group_c: assert property (s_write(OFFSET_GROUP_C) |=>
      run_ch11 == $past(hwdata[0])) else $error("group c write lost");
   a_reset_halts: assert property (disable iff (1'b0) reset |=> halted)
      else $error("run enable set after reset");
   a_standby_halts: assert property ((!quiet)[*3] |=> halted)
      else $error("run enable set in standby");
   a_pair_joint: assert property (run_ch1_b == run_ch2_b)
      else $error("channel 1 b and 2 b differ");
   a_ch10_aux_free: assert property (run_ch10_event && run_ch10_noise)
      else $error("channel 10 event or filter counter gated");
   a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_rdata_stands: assert property (!(hsel && hready && htrans[1] && !hwrite) |=>
      $stable(hrdata))
      else $error("read data changed without a read");
endmodule // tcs_start_ctrl_props

bind tcs_start_ctrl tcs_start_ctrl_props u_props (.clock, .reset, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .hw_standby, .sw_standby,
   .run_ch10, .run_ch10_event, .run_ch10_noise, .run_ch1_b, .run_ch2_b, .run_ch0,
   .run_ch7_d, .run_ch6_a, .run_ch11);

/* rtl/tcs_pkg.sv */
// Package of constants for the counter start control block
package tcs_pkg;

   localparam int unsigned ADDR_WIDTH = 8;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned REG_WIDTH  = 8;
   localparam int unsigned CNT_WIDTH  = 16;

   // Register byte addresses
   localparam logic [7:0] OFFSET_GROUP_A = 8'h00;
   localparam logic [7:0] OFFSET_GROUP_B = 8'h04;
   localparam logic [7:0] OFFSET_GROUP_C = 8'h08;
   localparam logic [7:0] OFFSET_CH11    = 8'h0C;

   // Reset values
   localparam logic [7:0]  RESET_GROUP_A = 8'h00;
   localparam logic [7:0]  RESET_GROUP_B = 8'h00;
   localparam logic [7:0]  RESET_GROUP_C = 8'h00;
   localparam logic [15:0] RESET_CH11    = 16'h0000;

   // Bit positions in group a
   localparam int unsigned BIT_RUN_CH10   = 7;
   localparam int unsigned BIT_RUN_CH5    = 6;
   localparam int unsigned BIT_RUN_CH4    = 5;
   localparam int unsigned BIT_RUN_CH3    = 4;
   localparam int unsigned BIT_RUN_CH12_B = 3;
   localparam int unsigned BIT_RUN_CH2_A  = 2;
   localparam int unsigned BIT_RUN_CH1_A  = 1;
   localparam int unsigned BIT_RUN_CH0    = 0;

   // Bit positions in group b
   localparam int unsigned BIT_RUN_CH7_D = 7;
   localparam int unsigned BIT_RUN_CH7_C = 6;
   localparam int unsigned BIT_RUN_CH7_B = 5;
   localparam int unsigned BIT_RUN_CH7_A = 4;
   localparam int unsigned BIT_RUN_CH6_D = 3;
   localparam int unsigned BIT_RUN_CH6_C = 2;
   localparam int unsigned BIT_RUN_CH6_B = 1;
   localparam int unsigned BIT_RUN_CH6_A = 0;

   // Bit position in group c and its writable mask
   localparam int unsigned BIT_RUN_CH11  = 0;
   localparam logic [7:0]  MASK_GROUP_C  = 8'h01;

   // Bus codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic       HRESP_OKAY    = 1'b0;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

/* rtl/tcs_run_counter.sv */
// Free-running counter that holds its value while halted
`timescale 1ns/1ps

module tcs_run_counter #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             run,
   input  wire logic             tick,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   output logic      [WIDTH-1:0] value
);

   // Refuse widths the counter cannot serve
   if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
      $error("tcs_run_counter: WIDTH must be 2 to 32");
   end

   // Load wins, then count while running, else hold
   always_ff @(posedge clock) begin
      if (reset) begin
         value <= '0;
      end else if (load) begin
         value <= load_value;
      end else if (run && tick) begin
         value <= value + WIDTH'(1);
      end
   end

endmodule // tcs_run_counter

/* rtl/tcs_start_ctrl.sv */
// Counter start registers with an AHB-Lite slave port
`timescale 1ns/1ps

// Overview of operation
// - Three start registers gate channels 0-5 and 10, channels 6-7, and channel 11.
// - All three groups clear to zero on reset and in either standby mode, halting all but the channel 10 event and noise filter counters.
// - Groups a and b are 8-bit read/write registers that read back what was written.
// - Group a bit 7 runs channel 10 counters a, c, d, e, f and g when set.
// - Channel 10 event and noise filter counters keep running regardless of bit 7.
// - Group a bits 6, 5 and 4 run counters of channels 5, 4 and 3.
// - Group a bit 3 runs channel 1 counter b and channel 2 counter b together.
// - Group a bits 2, 1 and 0 run channel 2 counter a, channel 1 counter a, channel 0.
// - Group b bits 7 to 4 run channel 7 counters d, c, b and a.
// - Group b bits 3 to 0 run channel 6 counters d, c, b and a.
// - Group c bit 0 runs the channel 11 counter and its other bits read zero.
module tcs_start_ctrl (
   input  wire logic                             clock,
   input  wire logic                             reset,
   input  wire logic                             hsel,
   input  wire logic [tcs_pkg::ADDR_WIDTH-1:0]   haddr,
   input  wire logic [1:0]                       htrans,
   input  wire logic                             hwrite,
   input  wire logic [2:0]                       hsize,
   input  wire logic [tcs_pkg::DATA_WIDTH-1:0]   hwdata,
   input  wire logic                             hready,
   output logic                                  hreadyout,
   output logic                                  hresp,
   output logic      [tcs_pkg::DATA_WIDTH-1:0]   hrdata,
   input  wire logic                             hw_standby,
   input  wire logic                             sw_standby,
   input  wire logic                             ch11_count_tick,
   output logic                                  run_ch10,
   output logic                                  run_ch10_event,
   output logic                                  run_ch10_noise,
   output logic                                  run_ch5,
   output logic                                  run_ch4,
   output logic                                  run_ch3,
   output logic                                  run_ch1_b,
   output logic                                  run_ch2_b,
   output logic                                  run_ch2_a,
   output logic                                  run_ch1_a,
   output logic                                  run_ch0,
   output logic                                  run_ch7_d,
   output logic                                  run_ch7_c,
   output logic                                  run_ch7_b,
   output logic                                  run_ch7_a,
   output logic                                  run_ch6_d,
   output logic                                  run_ch6_c,
   output logic                                  run_ch6_b,
   output logic                                  run_ch6_a,
   output logic                                  run_ch11,
   output logic      [tcs_pkg::CNT_WIDTH-1:0]    ch11_free_counter
);
   import tcs_pkg::*;

   // Standby pins pass two flip-flops
   logic                  hw_standby_meta;
   logic                  hw_standby_sync;
   logic                  sw_standby_meta;
   logic                  sw_standby_sync;
   logic                  standby;

   // Registered address phase
   logic                  phase_write;
   logic [ADDR_WIDTH-1:0] phase_addr;
   logic                  phase_low_lane;

   // Start registers
   logic [REG_WIDTH-1:0]  counter_start_group_a;
   logic [REG_WIDTH-1:0]  counter_start_group_b;
   logic [REG_WIDTH-1:0]  counter_start_group_c;
   logic [REG_WIDTH-1:0]  next_group_a;
   logic [REG_WIDTH-1:0]  next_group_b;
   logic [REG_WIDTH-1:0]  next_group_c;

   // Channel 11 counter
   logic                  ch11_load;
   logic [CNT_WIDTH-1:0]  ch11_value;
   logic [CNT_WIDTH-1:0]  next_ch11;

   // Bus decode
   logic                  take;
   logic                  wr_a;
   logic                  wr_b;
   logic                  wr_c;
   logic                  wr_ch11;
   logic [DATA_WIDTH-1:0] next_rdata;

   // True when the access covers byte lane 0 of its word
   function automatic logic covers_lane0(input logic [2:0] size,
                                         input logic [1:0] low);
      covers_lane0 = (size >= HSIZE_WORD) || (low == 2'b00);
   endfunction

   // True when the address falls in the word at the given offset
   function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr,
                                 input logic [7:0]            offset);
      hits = ({addr[ADDR_WIDTH-1:2], 2'b00} == offset);
   endfunction

   always_ff @(posedge clock) begin
      if (reset) begin
         hw_standby_meta <= 1'b0;
         hw_standby_sync <= 1'b0;
      end else begin
         hw_standby_meta <= hw_standby;
         hw_standby_sync <= hw_standby_meta;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         sw_standby_meta <= 1'b0;
         sw_standby_sync <= 1'b0;
      end else begin
         sw_standby_meta <= sw_standby;
         sw_standby_sync <= sw_standby_meta;
      end
   end

   assign standby = hw_standby_sync || sw_standby_sync;

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

   assign take = hsel && hready &&
                 (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // Capture the address phase
   always_ff @(posedge clock) begin
      if (reset) begin
         phase_write    <= 1'b0;
         phase_addr     <= '0;
         phase_low_lane <= 1'b0;
      end else if (hready) begin
         phase_write    <= take && hwrite;
         phase_addr     <= haddr;
         phase_low_lane <= covers_lane0(hsize, haddr[1:0]);
      end
   end

   assign wr_a    = phase_write && phase_low_lane && hits(phase_addr, OFFSET_GROUP_A);
   assign wr_b    = phase_write && phase_low_lane && hits(phase_addr, OFFSET_GROUP_B);
   assign wr_c    = phase_write && phase_low_lane && hits(phase_addr, OFFSET_GROUP_C);
   assign wr_ch11 = phase_write && phase_low_lane && hits(phase_addr, OFFSET_CH11);

   // Next register values; standby clear wins over a write
   always_comb begin
      next_group_a = counter_start_group_a;
      next_group_b = counter_start_group_b;
      next_group_c = counter_start_group_c;
      if (standby) begin
         next_group_a = RESET_GROUP_A;
         next_group_b = RESET_GROUP_B;
         next_group_c = RESET_GROUP_C;
      end else begin
         if (wr_a) begin
            next_group_a = hwdata[REG_WIDTH-1:0];
         end
         if (wr_b) begin
            next_group_b = hwdata[REG_WIDTH-1:0];
         end
         if (wr_c) begin
            next_group_c = hwdata[REG_WIDTH-1:0] & MASK_GROUP_C;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         counter_start_group_a <= RESET_GROUP_A;
      end else begin
         counter_start_group_a <= next_group_a;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         counter_start_group_b <= RESET_GROUP_B;
      end else begin
         counter_start_group_b <= next_group_b;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         counter_start_group_c <= RESET_GROUP_C;
      end else begin
         counter_start_group_c <= next_group_c;
      end
   end

   // Channel 11 counter, loadable from software
   assign ch11_load = wr_ch11;

   tcs_run_counter #(
      .WIDTH (CNT_WIDTH)
   ) u_ch11_counter (
      .clock      (clock),
      .reset      (reset),
      .run        (counter_start_group_c[BIT_RUN_CH11]),
      .tick       (ch11_count_tick),
      .load       (ch11_load),
      .load_value (hwdata[CNT_WIDTH-1:0]),
      .value      (ch11_value)
   );

   assign ch11_free_counter = ch11_value;

   // Read value reflects a write finishing in the same edge
   always_comb begin
      next_ch11 = ch11_load ? hwdata[CNT_WIDTH-1:0] : ch11_value;
      next_rdata = '0;
      if (haddr[ADDR_WIDTH-1:2] == OFFSET_GROUP_A[ADDR_WIDTH-1:2]) begin
         next_rdata[REG_WIDTH-1:0] = next_group_a;
      end else if (haddr[ADDR_WIDTH-1:2] == OFFSET_GROUP_B[ADDR_WIDTH-1:2]) begin
         next_rdata[REG_WIDTH-1:0] = next_group_b;
      end else if (haddr[ADDR_WIDTH-1:2] == OFFSET_GROUP_C[ADDR_WIDTH-1:2]) begin
         next_rdata[REG_WIDTH-1:0] = next_group_c;
      end else if (haddr[ADDR_WIDTH-1:2] == OFFSET_CH11[ADDR_WIDTH-1:2]) begin
         next_rdata[CNT_WIDTH-1:0] = next_ch11;
      end else begin
         next_rdata = '0;
      end
   end

   // Read data registered at the address phase edge
   always_ff @(posedge clock) begin
      if (reset) begin
         hrdata <= '0;
      end else if (take && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // Run enables straight from register bits
   assign run_ch10  = counter_start_group_a[BIT_RUN_CH10];
   assign run_ch5   = counter_start_group_a[BIT_RUN_CH5];
   assign run_ch4   = counter_start_group_a[BIT_RUN_CH4];
   assign run_ch3   = counter_start_group_a[BIT_RUN_CH3];
   assign run_ch1_b = counter_start_group_a[BIT_RUN_CH12_B];
   assign run_ch2_b = counter_start_group_a[BIT_RUN_CH12_B];
   assign run_ch2_a = counter_start_group_a[BIT_RUN_CH2_A];
   assign run_ch1_a = counter_start_group_a[BIT_RUN_CH1_A];
   assign run_ch0   = counter_start_group_a[BIT_RUN_CH0];

   assign run_ch7_d = counter_start_group_b[BIT_RUN_CH7_D];
   assign run_ch7_c = counter_start_group_b[BIT_RUN_CH7_C];
   assign run_ch7_b = counter_start_group_b[BIT_RUN_CH7_B];
   assign run_ch7_a = counter_start_group_b[BIT_RUN_CH7_A];
   assign run_ch6_d = counter_start_group_b[BIT_RUN_CH6_D];
   assign run_ch6_c = counter_start_group_b[BIT_RUN_CH6_C];
   assign run_ch6_b = counter_start_group_b[BIT_RUN_CH6_B];
   assign run_ch6_a = counter_start_group_b[BIT_RUN_CH6_A];

   assign run_ch11  = counter_start_group_c[BIT_RUN_CH11];

   // Event and noise filter counters of channel 10 are never gated
   assign run_ch10_event = 1'b1;
   assign run_ch10_noise = 1'b1;

endmodule // tcs_start_ctrl
